// File: design/rmis_bank.sv
// remappable input select bank with axi4-lite register access
`timescale 1ns/10ps

// What this block does
// [R1] all selector bits read/write, clear at reset
// [R2] reg 13 high byte picks pwm input 11
// [R3] reg 13 low byte picks pwm input 10
// [R4] reg 14 high byte picks encoder1 phase b
// [R5] reg 14 low byte picks encoder1 phase a
// [R6] reg 15 high byte picks encoder1 home
// [R7] reg 15 low byte picks encoder1 index
// [R8] reg 16 high byte picks encoder2 phase b
// [R9] reg 16 low byte picks encoder2 phase a
// [R10] reg 17 high byte picks encoder2 home
// [R11] reg 17 low byte picks encoder2 index
// [R12] reg 18 high byte picks serial1 dsr
// [R13] reg 18 low byte picks serial1 receive
// [R14] reg 19 high byte picks serial2 dsr
// [R15] reg 19 low byte picks serial2 receive
// [R16] reg 20 high byte picks spi1 clock
// [R17] reg 20 low byte picks spi1 data
// [R18] reg 21 high byte picks reference clock
// [R19] reg 21 low byte picks spi1 select
// [R20] one shared lookup maps selector to pin
module rmis_bank
  import rmis_pkg::*;
(
  // clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // axi4-lite write address
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [RMIS_ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic [2:0]                s_axi_awprot,
  // axi4-lite write data
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  input  wire logic [RMIS_DATA_W-1:0]    s_axi_wdata,
  input  wire logic [RMIS_DATA_W/8-1:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  output logic [1:0]                     s_axi_bresp,
  // axi4-lite read address
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  input  wire logic [RMIS_ADDR_W-1:0]    s_axi_araddr,
  input  wire logic [2:0]                s_axi_arprot,
  // axi4-lite read data
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic [RMIS_DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  // remappable device pins
  input  wire logic [RMIS_PIN_COUNT-1:0] remappable_pin,
  // pwm control inputs
  output logic                           pwm_control_input_10,
  output logic                           pwm_control_input_11,
  // first quadrature encoder inputs
  output logic                           first_quadrature_encoder_a,
  output logic                           first_quadrature_encoder_b,
  output logic                           first_quadrature_encoder_index,
  output logic                           first_quadrature_encoder_home,
  // second quadrature encoder inputs
  output logic                           second_quadrature_encoder_a,
  output logic                           second_quadrature_encoder_b,
  output logic                           second_quadrature_encoder_index,
  output logic                           second_quadrature_encoder_home,
  // serial port inputs
  output logic                           serial1_rx_input,
  output logic                           serial1_dsr_input,
  output logic                           serial2_rx_input,
  output logic                           serial2_dsr_input,
  // spi port 1 inputs
  output logic                           spi_port1_data_input,
  output logic                           spi_port1_clock_input,
  output logic                           spi_port1_select_input,
  // reference clock input
  output logic                           reference_clock_input
);

  // whole block state
  typedef struct packed {
    logic [RMIS_NUM_REGS-1:0][RMIS_REG_W-1:0] sel;
    logic                                     aw_full;
    logic [RMIS_ADDR_W-1:0]                   aw_addr;
    logic                                     w_full;
    logic [RMIS_DATA_W-1:0]                   w_data;
    logic [RMIS_DATA_W/8-1:0]                 w_strb;
    logic                                     bvalid;
    logic [1:0]                               bresp;
    logic                                     rvalid;
    logic [RMIS_DATA_W-1:0]                   rdata;
    logic [1:0]                               rresp;
    logic [RMIS_NUM_FIELD-1:0]                route;
  } rmis_state_t;

  localparam rmis_state_t RMIS_RESET_STATE = '{
    sel:     {RMIS_NUM_REGS{RMIS_SELECT_RESET}},
    default: '0
  };

  rmis_state_t state_reg;
  rmis_state_t state_next;

  logic [RMIS_FIELD_W-1:0]   field_sel [RMIS_NUM_FIELD];
  logic [RMIS_NUM_FIELD-1:0] routed;

  // word offset to register index; index 15 means unmapped
  function automatic logic [3:0] rmis_decode(input logic [RMIS_ADDR_W-1:0] addr);
    logic [RMIS_ADDR_W-1:0] a;
    a = {addr[RMIS_ADDR_W-1:2], 2'b00};
    case (a)
      RMIS_PWM_IN_10_11_SELECT_OFS:     rmis_decode = 4'h0;
      RMIS_ENCODER1_PHASE_SELECT_OFS:   rmis_decode = 4'h1;
      RMIS_ENCODER1_HOME_INDEX_SEL_OFS: rmis_decode = 4'h2;
      RMIS_ENCODER2_PHASE_SELECT_OFS:   rmis_decode = 4'h3;
      RMIS_ENCODER2_HOME_INDEX_SEL_OFS: rmis_decode = 4'h4;
      RMIS_SERIAL1_INPUT_SELECT_OFS:    rmis_decode = 4'h5;
      RMIS_SERIAL2_INPUT_SELECT_OFS:    rmis_decode = 4'h6;
      RMIS_SPI1_CLOCK_DATA_SELECT_OFS:  rmis_decode = 4'h7;
      RMIS_REFCLK_SPI1_SELECT_OFS:      rmis_decode = 4'h8;
      default:                          rmis_decode = 4'hf;
    endcase
  endfunction : rmis_decode

  // shared selector-to-pin lookup; value zero routes a constant low
  function automatic logic rmis_pin_lookup(
    input logic [RMIS_FIELD_W-1:0]   value,
    input logic [RMIS_PIN_COUNT-1:0] pins
  );
    rmis_pin_lookup = (value == RMIS_SEL_NONE) ? 1'b0 : pins[value]; // [R20]
  endfunction : rmis_pin_lookup

  // one lookup per field; even fields are low bytes, odd are high bytes
  for (genvar f = 0; f < RMIS_NUM_FIELD; f++) begin : g_field
    localparam int unsigned LSB = (f % 2 == 0) ? RMIS_LO_LSB : RMIS_HI_LSB;
    assign field_sel[f] = state_reg.sel[f/2][LSB +: RMIS_FIELD_W];
    assign routed[f]    = rmis_pin_lookup(field_sel[f], remappable_pin); // [R20]
  end

  // handshakes; a held address or data waits for its partner
  assign s_axi_awready = !state_reg.aw_full && !state_reg.bvalid;
  assign s_axi_wready  = !state_reg.w_full && !state_reg.bvalid;
  assign s_axi_arready = !state_reg.rvalid;

  // next state: bus slave, register file and routed inputs
  always_comb begin
    logic [3:0]            widx;
    logic [3:0]            ridx;
    logic [RMIS_REG_W-1:0] merged;
    widx   = rmis_decode(state_reg.aw_addr);
    ridx   = rmis_decode(s_axi_araddr);
    merged = '0;
    state_next = state_reg;
    // capture address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      state_next.aw_full = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_next.w_full = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    // commit once both halves are held; upper strobes land on nothing
    if (state_reg.aw_full && state_reg.w_full && !state_reg.bvalid) begin
      state_next.aw_full = 1'b0;
      state_next.w_full  = 1'b0;
      state_next.bvalid  = 1'b1;
      if (widx < 4'(RMIS_NUM_REGS)) begin
        merged = state_reg.sel[widx];
        if (state_reg.w_strb[0]) begin
          merged[7:0] = state_reg.w_data[7:0]; // [R1]
        end
        if (state_reg.w_strb[1]) begin
          merged[15:8] = state_reg.w_data[15:8]; // [R1]
        end
        state_next.sel[widx] = merged; // [R1]
        state_next.bresp     = RMIS_RESP_OKAY;
      end else begin
        state_next.bresp = RMIS_RESP_SLVERR;
      end
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    // reads answer the cycle after the address is taken
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      state_next.rvalid = 1'b1;
      if (ridx < 4'(RMIS_NUM_REGS)) begin
        state_next.rdata = {16'h0000, state_reg.sel[ridx]}; // [R1]
        state_next.rresp = RMIS_RESP_OKAY;
      end else begin
        state_next.rdata = 32'h0000_0000;
        state_next.rresp = RMIS_RESP_SLVERR;
      end
    end
    // routed inputs are registered so peripherals see clean levels
    state_next.route = routed;
  end

  // single state register, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= RMIS_RESET_STATE; // [R1]
    end else begin
      state_reg <= state_next;
    end
  end

  // bus outputs from state
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp  = state_reg.bresp;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata  = state_reg.rdata;
  assign s_axi_rresp  = state_reg.rresp;

  // peripheral inputs, field order follows register order
  assign pwm_control_input_10            = state_reg.route[0];  // [R3]
  assign pwm_control_input_11            = state_reg.route[1];  // [R2]
  assign first_quadrature_encoder_a      = state_reg.route[2];  // [R5]
  assign first_quadrature_encoder_b      = state_reg.route[3];  // [R4]
  assign first_quadrature_encoder_index  = state_reg.route[4];  // [R7]
  assign first_quadrature_encoder_home   = state_reg.route[5];  // [R6]
  assign second_quadrature_encoder_a     = state_reg.route[6];  // [R9]
  assign second_quadrature_encoder_b     = state_reg.route[7];  // [R8]
  assign second_quadrature_encoder_index = state_reg.route[8];  // [R11]
  assign second_quadrature_encoder_home  = state_reg.route[9];  // [R10]
  assign serial1_rx_input                = state_reg.route[10]; // [R13]
  assign serial1_dsr_input               = state_reg.route[11]; // [R12]
  assign serial2_rx_input                = state_reg.route[12]; // [R15]
  assign serial2_dsr_input               = state_reg.route[13]; // [R14]
  assign spi_port1_data_input            = state_reg.route[14]; // [R17]
  assign spi_port1_clock_input           = state_reg.route[15]; // [R16]
  assign spi_port1_select_input          = state_reg.route[16]; // [R19]
  assign reference_clock_input           = state_reg.route[17]; // [R18]

endmodule : rmis_bank

// File: design/rmis_pkg.sv
// constants for the remappable input select bank
package rmis_pkg;

  // bus and field geometry
  localparam int unsigned RMIS_ADDR_W    = 8;
  localparam int unsigned RMIS_DATA_W    = 32;
  localparam int unsigned RMIS_REG_W     = 16;
  localparam int unsigned RMIS_FIELD_W   = 8;
  localparam int unsigned RMIS_NUM_REGS  = 9;
  localparam int unsigned RMIS_NUM_FIELD = 18;
  localparam int unsigned RMIS_LO_LSB    = 0;
  localparam int unsigned RMIS_HI_LSB    = 8;

  // width of the remappable pin bus the selector lookup indexes; slot zero is never routed
  localparam int unsigned RMIS_PIN_COUNT = 256;
  // selector value that routes a constant low instead of a pin
  localparam logic [7:0]  RMIS_SEL_NONE  = 8'h00;

  // register byte offsets
  localparam logic [7:0] RMIS_PWM_IN_10_11_SELECT_OFS       = 8'h00;
  localparam logic [7:0] RMIS_ENCODER1_PHASE_SELECT_OFS     = 8'h04;
  localparam logic [7:0] RMIS_ENCODER1_HOME_INDEX_SEL_OFS   = 8'h08;
  localparam logic [7:0] RMIS_ENCODER2_PHASE_SELECT_OFS     = 8'h0c;
  localparam logic [7:0] RMIS_ENCODER2_HOME_INDEX_SEL_OFS   = 8'h10;
  localparam logic [7:0] RMIS_SERIAL1_INPUT_SELECT_OFS      = 8'h14;
  localparam logic [7:0] RMIS_SERIAL2_INPUT_SELECT_OFS      = 8'h18;
  localparam logic [7:0] RMIS_SPI1_CLOCK_DATA_SELECT_OFS    = 8'h1c;
  localparam logic [7:0] RMIS_REFCLK_SPI1_SELECT_OFS        = 8'h20;

  // every selector register clears to this
  localparam logic [15:0] RMIS_SELECT_RESET = 16'h0000;

  // axi response codes
  localparam logic [1:0] RMIS_RESP_OKAY   = 2'b00;
  localparam logic [1:0] RMIS_RESP_SLVERR = 2'b10;

endpackage : rmis_pkg

// File: testbench/rmis_bank_asserts.sv
// bus handshake checker for the input select bank
`timescale 1ns/10ps
module rmis_bank_asserts
  import rmis_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  // read channels
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // two routed outputs
  input wire logic        pwm_control_input_10,
  input wire logic        reference_clock_input
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // both write halves taken at one edge
  sequence s_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // read address taken
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_write_answer: assert property (s_w_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_bresp_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_write_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during data");
  a_unmapped_read: assert property (
    s_ar_taken and s_axi_araddr > 8'h23
    |=> s_axi_rresp == RMIS_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_mapped_read: assert property (
    s_ar_taken and s_axi_araddr <= 8'h23
    |=> s_axi_rresp == RMIS_RESP_OKAY && s_axi_rdata[31:16] == 16'h0000)
    else $error("mapped read wrong");
  a_reset_clear: assert property (
    $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
      && !pwm_control_input_10 && !reference_clock_input)
    else $error("state not cleared by reset");
endmodule : rmis_bank_asserts

bind rmis_bank rmis_bank_asserts u_asserts (.*);

// File: testbench/rmis_pin_model.sv
// far-side model driving the remappable pin levels
`timescale 1ns/10ps
module rmis_pin_model (
  // clock
  input  wire logic         aclk,
  // levels chosen by the bench
  input  wire logic [255:0] level,
  // pins seen by the bank
  output logic      [255:0] remappable_pin
);
  // slot zero is no pin; it toggles so that a leak of slot zero shows
  logic zero_slot = 1'b0;
  always @(posedge aclk) zero_slot <= ~zero_slot;
  assign remappable_pin = {level[255:1], zero_slot};
endmodule : rmis_pin_model

// File: testbench/testbench.sv
// self-checking bench for the input select bank
`timescale 1ns/10ps
module testbench
  import rmis_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [255:0] remappable_pin, level = '1;
  wire [17:0] outs;
  logic [15:0] sel [9];
  logic [15:0] v;
  int failures = 0, checked = 0, cyc = 0;
  // a slow master raises bready and rready only after it sees the answer
  bit slow = 1'b0;
  rmis_pin_model pins (.aclk(aclk), .level(level), .remappable_pin(remappable_pin));
  rmis_bank dut (.*, .pwm_control_input_10(outs[0]), .pwm_control_input_11(outs[1]),
    .first_quadrature_encoder_a(outs[2]), .first_quadrature_encoder_b(outs[3]),
    .first_quadrature_encoder_index(outs[4]), .first_quadrature_encoder_home(outs[5]),
    .second_quadrature_encoder_a(outs[6]), .second_quadrature_encoder_b(outs[7]),
    .second_quadrature_encoder_index(outs[8]), .second_quadrature_encoder_home(outs[9]),
    .serial1_rx_input(outs[10]), .serial1_dsr_input(outs[11]), .serial2_rx_input(outs[12]),
    .serial2_dsr_input(outs[13]), .spi_port1_data_input(outs[14]),
    .spi_port1_clock_input(outs[15]), .spi_port1_select_input(outs[16]),
    .reference_clock_input(outs[17]));
  // 125 MHz clock and a hang limit well above the run length
  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic chk32(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask : chk32
  task automatic chk1(input int i);
    checked++;
    if (outs[i] !== exp_out(i)) begin
      failures++;
      $display("unexpected at %0t: output %0d got %b", $time, i, outs[i]);
    end
  endtask : chk1
  // write: both halves offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dd, input logic [3:0] s);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= dd;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= !slow;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1 && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid === 1'b1 && s_axi_bready));
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  // read: response taken at the edge where rvalid and rready are both high
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= !slow;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1 && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid === 1'b1 && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // selector zero gives low, otherwise the chosen pin level
  function automatic logic exp_out(int i);
    logic [7:0] b;
    b = i[0] ? sel[i/2][15:8] : sel[i/2][7:0];
    return (b == 8'h00) ? 1'b0 : level[b];
  endfunction : exp_out
  task automatic chk_outs();
    repeat (3) @(posedge aclk);
    for (int i = 0; i < 6; i++) chk1(i);
    for (int i = 6; i < 12; i++) chk1(i);
    for (int i = 12; i < 18; i++) chk1(i);
  endtask : chk_outs
  // main sequence
  initial begin
    void'($urandom(32'h036cfa2b));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (sel[k]) sel[k] = 16'h0000;
    chk_outs();
    for (int k = 0; k < 9; k++) begin
      rd(8'(k * 4));
      chk32(d, 32'h0, "reset value");
    end
    // the middle pass holds the answer back one cycle at the master
    for (int n = 0; n < 3; n++) begin
      slow = (n == 1);
      for (int k = 0; k < 9; k++) begin
        v = (n == 0) ? 16'hff01 : 16'($urandom);
        wr(8'(k * 4), {16'($urandom), v}, 4'hf);
        chk32({30'h0, r}, {30'h0, RMIS_RESP_OKAY}, "write okay");
        rd(8'(k * 4));
        sel[k] = v;
        chk32(d, {16'h0000, v}, "readback");
      end
      for (int j = 0; j < 8; j++) level[j*32 +: 32] <= $urandom;
      chk_outs();
      level <= ~level;
      chk_outs();
    end
    // byte strobes: only lanes 0 and 1 write
    wr(8'h00, 32'h0000aa55, 4'b0001);
    sel[0][7:0] = 8'h55;
    wr(8'h00, 32'hffffffff, 4'b1100);
    rd(8'h00);
    chk32(d, {16'h0000, sel[0]}, "strobe");
    // unmapped place next to the last register
    wr(8'h24, 32'hffffffff, 4'hf);
    chk32({30'h0, r}, {30'h0, RMIS_RESP_SLVERR}, "write error");
    rd(8'h24);
    chk32({d[31:2], r}, {30'h0, RMIS_RESP_SLVERR}, "read error");
    rd(8'h20);
    chk32(d, {16'h0000, sel[8]}, "neighbour");
    chk_outs();
    // second reset in mid-run
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (sel[k]) sel[k] = 16'h0000;
    for (int k = 0; k < 9; k++) begin
      rd(8'(k * 4));
      chk32(d, 32'h0, "after reset");
    end
    chk_outs();
    final_report();
  end
endmodule : testbench
